/* spp_params.svh */
`ifndef SPP_PARAMS_SVH
`define SPP_PARAMS_SVH
// register byte addresses
`define SPP_ADDR_ROUTE 8'hdd
`define SPP_ADDR_DATA 8'he0
`define SPP_ADDR_RATE 8'he1
`define SPP_ADDR_MODE 8'he2
// mode register bit positions
`define SPP_MODE_RUN 7
`define SPP_MODE_IE 6
`define SPP_MODE_CPHA 5
`define SPP_MODE_CLK 4
`define SPP_MODE_SIN 3
`define SPP_MODE_STRT 2
`define SPP_MODE_FILT 1
`define SPP_MODE_CPOL 0
// rate/frame/flag register fields
`define SPP_RATE_FLAG 7
`define SPP_RATE_LEN_HI 6
`define SPP_RATE_LEN_LO 3
`define SPP_RATE_CD_HI 2
`define SPP_RATE_CD_LO 0
// reset values
`define SPP_MODE_RST 8'h00
`define SPP_RATE_RST 8'h00
// core cycle clock is the system clock divided by this
`define SPP_CORE_DIV 13
`define SPP_CD_MAX_RATIO 256
`endif

/* spp_pkg.sv */
package spp_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARM,
    ST_SHIFT
  } spp_state_t;
endpackage

/* spp_in_filter.sv */
`timescale 1ns/1ps
module spp_in_filter (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // pin side
  input wire logic pinIn,
  input wire logic bypass,
  // cleaned level
  output logic filt
);
  logic sync1_r;
  logic sync2_r;
  logic sync3_r;

  // two-stage synchroniser; sync1_r feeds only sync2_r
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end else begin
      sync1_r <= pinIn;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // a level must hold two samples to pass, so a one-cycle pulse dies
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      filt <= 1'b0;
    end else if (bypass) begin
      filt <= sync2_r;
    end else if (sync2_r == sync3_r) begin
      filt <= sync2_r;
    end
  end
endmodule

/* spp_top.sv */
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`include "spp_params.svh"
// How it works
// - hardware clears run at frame end, requests interrupt if enabled
// - software clearing run aborts at once, requests interrupt if enabled
// - interrupt enable gates the request line; cleared means no request
// - phase 0: msb out at load; phase 1: msb out on first change edge
// - clock select high: master, drives clock pin; low: slave on pin
// - input-select low shifts in zeros; high shifts in serial input
// - gated start waits for a serial input rise while run is set
// - a gated transfer keeps going when serial input falls again
// - inputs filtered of short pulses unless filter-disable is set
// - polarity picks capture edge and change edge of the bit clock
// - rate register writes ignored while running; flag only cleared
// - flag set at every frame end when interrupt enable is set
// - frame length 1 to 15 bits; code 0 reserved, never starts
// - master bit clock divided by 1,2,4..64 or 256 from core clock
// - data register writes ignored while running
// - msb first on both ends
// - route register bit 0 gives the serial output pin to the port
// - own flag readable to tell this source from the port source
module spp_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // serial pins
  input wire logic sinPin,
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe,
  output logic soutData,
  output logic soutSel,
  // interrupt request toward vector 2
  output logic irqReq
);
  import spp_pkg::*;

  spp_state_t state_r;
  logic ieR, cphaR, clkSelR, spinR, sstrtR, efiltR, cpolR;
  logic flagR, routeR, outBitR, sckOutR, sckPrevR, sinPrevR;
  logic [3:0] lenR;
  logic [2:0] cdR;
  logic [7:0] srR;
  logic [3:0] capCnt_r;
  logic [3:0] baseCnt_r;
  logic [7:0] rateCnt_r;
  logic sinF, sckF;
  logic busy, modeWr, rateWr, dataWr, routeWr;
  logic baseTick, divTick, ev, newLvl, capEv, chgEv;
  logic inBit, lastCap, done, abort, startNow;
  logic [7:0] ratioM1;

  // input conditioning, one filter per pin
  spp_in_filter u_sin_filt (
    .sys_clk(sys_clk),
    .rst(rst),
    .pinIn(sinPin),
    .bypass(efiltR),
    .filt(sinF)
  );
  spp_in_filter u_sck_filt (
    .sys_clk(sys_clk),
    .rst(rst),
    .pinIn(sckIn),
    .bypass(efiltR),
    .filt(sckF)
  );

  // address decode
  assign busy = (state_r != ST_IDLE);
  assign modeWr = regWr && (regAddr == `SPP_ADDR_MODE);
  assign rateWr = regWr && (regAddr == `SPP_ADDR_RATE);
  assign dataWr = regWr && (regAddr == `SPP_ADDR_DATA);
  assign routeWr = regWr && (regAddr == `SPP_ADDR_ROUTE);

  // core cycle clock enable from the system clock
  always_ff @(posedge sys_clk) begin
    if (rst || !busy) begin
      baseCnt_r <= 4'h0;
    end else if (baseTick) begin
      baseCnt_r <= 4'h0;
    end else begin
      baseCnt_r <= baseCnt_r + 4'h1;
    end
  end
  assign baseTick = busy && (baseCnt_r == 4'(`SPP_CORE_DIV - 1));

  // ratio code to terminal count; code 7 jumps to 256, not 128
  always_comb begin
    if (cdR == 3'h7) begin
      ratioM1 = 8'(`SPP_CD_MAX_RATIO - 1);
    end else begin
      ratioM1 = 8'((9'h001 << cdR) - 9'h001);
    end
  end

  // bit clock divider, one edge of the bit clock per tick
  always_ff @(posedge sys_clk) begin
    if (rst || state_r != ST_SHIFT) begin
      rateCnt_r <= 8'h00;
    end else if (baseTick) begin
      if (rateCnt_r == ratioM1) begin
        rateCnt_r <= 8'h00;
      end else begin
        rateCnt_r <= rateCnt_r + 8'h01;
      end
    end
  end
  assign divTick = (state_r == ST_SHIFT) && baseTick &&
                   (rateCnt_r == ratioM1);

  // edge events: own clock as master, pin clock as slave
  always_comb begin
    if (clkSelR) begin
      ev = divTick;
      newLvl = ~sckOutR;
    end else begin
      ev = (state_r == ST_SHIFT) && (sckF != sckPrevR);
      newLvl = sckF;
    end
  end
  // polarity 0 captures on rising, 1 on falling
  assign capEv = ev && (newLvl == ~cpolR);
  assign chgEv = ev && (newLvl == cpolR);
  assign inBit = spinR ? sinF : 1'b0;
  assign lastCap = capEv && (capCnt_r == lenR - 4'h1);

  // master phase 0 ends on the trailing change edge, otherwise on capture
  always_comb begin
    if (clkSelR && !cphaR) begin
      done = chgEv && (capCnt_r == lenR);
    end else begin
      done = lastCap;
    end
  end
  assign abort = busy && modeWr && !regWdata[`SPP_MODE_RUN];
  // gated start needs a rise, so a level already high does not count
  assign startNow = (state_r == ST_ARM) && sinF && !sinPrevR;

  // transfer sequencer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (modeWr && regWdata[`SPP_MODE_RUN] && lenR != 4'h0) begin
            if (regWdata[`SPP_MODE_STRT]) begin
              state_r <= ST_ARM;
            end else begin
              state_r <= ST_SHIFT;
            end
          end
        end
        ST_ARM: begin
          if (abort) begin
            state_r <= ST_IDLE;
          end else if (startNow) begin
            state_r <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          // a later fall on the serial input is not looked at here
          if (abort || done) begin
            state_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // mode register; only the run bit acts while busy
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      {ieR, cphaR, clkSelR, spinR} <= 4'(`SPP_MODE_RST >> `SPP_MODE_SIN);
      {sstrtR, efiltR, cpolR} <= 3'(`SPP_MODE_RST);
    end else if (modeWr && !busy) begin
      ieR <= regWdata[`SPP_MODE_IE];
      cphaR <= regWdata[`SPP_MODE_CPHA];
      clkSelR <= regWdata[`SPP_MODE_CLK];
      spinR <= regWdata[`SPP_MODE_SIN];
      sstrtR <= regWdata[`SPP_MODE_STRT];
      efiltR <= regWdata[`SPP_MODE_FILT];
      cpolR <= regWdata[`SPP_MODE_CPOL];
    end
  end

  // rate/frame fields, locked while a transfer is live
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lenR <= 4'(`SPP_RATE_RST >> `SPP_RATE_LEN_LO);
      cdR <= 3'(`SPP_RATE_RST);
    end else if (rateWr && !busy) begin
      lenR <= regWdata[`SPP_RATE_LEN_HI:`SPP_RATE_LEN_LO];
      cdR <= regWdata[`SPP_RATE_CD_HI:`SPP_RATE_CD_LO];
    end
  end

  // interrupt flag: set at frame end or abort when interrupt enable is set, set beats clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flagR <= 1'b0;
    end else if ((done || abort) && ieR) begin
      flagR <= 1'b1;
    end else if (rateWr && !busy && !regWdata[`SPP_RATE_FLAG]) begin
      flagR <= 1'b0;
    end
  end
  assign irqReq = flagR && ieR;

  // output route bit; write-only, read returns zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      routeR <= 1'b0;
    end else if (routeWr) begin
      routeR <= regWdata[0];
    end
  end

  // shift register, msb first, captured bits enter at bit 0
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      srR <= 8'h00;
    end else if (dataWr && !busy) begin
      srR <= regWdata;
    end else if (capEv && state_r == ST_SHIFT) begin
      srR <= {srR[6:0], inBit};
    end
  end

  // captured bit count
  always_ff @(posedge sys_clk) begin
    if (rst || state_r != ST_SHIFT) begin
      capCnt_r <= 4'h0;
    end else if (capEv) begin
      capCnt_r <= capCnt_r + 4'h1;
    end
  end

  // serial output bit: follows msb while idle in phase 0
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      outBitR <= 1'b0;
    end else if (state_r != ST_SHIFT) begin
      if (!cphaR) begin
        outBitR <= srR[7];
      end
    end else if (chgEv) begin
      outBitR <= srR[7];
    end
  end

  // master clock pin level; parks so the first edge has the right kind
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sckOutR <= 1'b0;
    end else if (state_r != ST_SHIFT) begin
      sckOutR <= cpolR ^ cphaR;
    end else if (divTick) begin
      sckOutR <= ~sckOutR;
    end
  end

  // previous filtered levels for edge detection
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sckPrevR <= 1'b0;
      sinPrevR <= 1'b0;
    end else begin
      sckPrevR <= sckF;
      sinPrevR <= sinF;
    end
  end

  // pin outputs
  assign sckOut = sckOutR;
  assign sckOe = clkSelR;
  assign soutData = outBitR;
  assign soutSel = routeR;

  // read data, valid the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      unique case (regAddr)
        `SPP_ADDR_DATA: regRdata <= srR;
        `SPP_ADDR_RATE: regRdata <= {flagR, lenR, cdR};
        `SPP_ADDR_MODE: regRdata <= {busy, ieR, cphaR, clkSelR,
                                     spinR, sstrtR, efiltR, cpolR};
        default: regRdata <= 8'h00;
      endcase
    end
  end

  property p_done_idle;
    @(posedge sys_clk) disable iff (rst)
    (state_r == ST_SHIFT && done) |=> (state_r == ST_IDLE && !busy);
  endproperty
  a_done_idle: assert property (p_done_idle)
    else $error("run not cleared at frame end");

  property p_abort;
    @(posedge sys_clk) disable iff (rst)
    (abort && ieR) |=> (state_r == ST_IDLE && irqReq);
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort did not stop and request");

  property p_no_ie;
    @(posedge sys_clk) disable iff (rst)
    (!ieR && !flagR) |=> !irqReq;
  endproperty
  a_no_ie: assert property (p_no_ie)
    else $error("request without enable");

  property p_phase0_out;
    @(posedge sys_clk) disable iff (rst)
    (state_r == ST_IDLE && !cphaR) ##1 (state_r == ST_IDLE)
      |-> (soutData == $past(srR[7]));
  endproperty
  a_phase0_out: assert property (p_phase0_out)
    else $error("msb not on output at load");

  property p_park;
    @(posedge sys_clk) disable iff (rst)
    (state_r == ST_IDLE) [*2] |-> (sckOut == $past(cpolR ^ cphaR));
  endproperty
  a_park: assert property (p_park)
    else $error("clock not parked at idle level");

  property p_zero_in;
    @(posedge sys_clk) disable iff (rst)
    (state_r == ST_SHIFT && capEv && !spinR) |=> (srR[0] == 1'b0);
  endproperty
  a_zero_in: assert property (p_zero_in)
    else $error("nonzero bit shifted with input off");

  property p_gate;
    @(posedge sys_clk) disable iff (rst)
    (state_r == ST_ARM && !abort && !(sinF && !sinPrevR))
      |=> (state_r == ST_ARM);
  endproperty
  a_gate: assert property (p_gate)
    else $error("gated start left arm without rise");

  property p_rate_lock;
    @(posedge sys_clk) disable iff (rst)
    (busy && rateWr) |=> (lenR == $past(lenR) && cdR == $past(cdR));
  endproperty
  a_rate_lock: assert property (p_rate_lock)
    else $error("rate register written while running");

  property p_data_lock;
    @(posedge sys_clk) disable iff (rst)
    (busy && dataWr && !capEv) |=> (srR == $past(srR));
  endproperty
  a_data_lock: assert property (p_data_lock)
    else $error("data register written while running");

  property p_base_gap;
    @(posedge sys_clk) disable iff (rst)
    baseTick |=> !baseTick [*8];
  endproperty
  a_base_gap: assert property (p_base_gap)
    else $error("core cycle enable too frequent");

  property p_flag_set;
    @(posedge sys_clk) disable iff (rst)
    (done && ieR && state_r == ST_SHIFT) |=> flagR ##1 flagR;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("flag not set at frame end");
endmodule

/* spp_far_end.sv */
`timescale 1ns/1ps
module spp_far_end (
  // clock
  input wire logic sys_clk,
  // serial link, seen from the far end
  input wire logic sck,
  input wire logic sout,
  output logic sin,
  // setup from the bench
  input wire logic cpol,
  input wire logic load,
  input wire logic [7:0] txByte,
  output logic [7:0] rxByte,
  output logic [3:0] capCnt
);
  logic sckQ;
  logic capEdge;
  logic chgEdge;
  // capture edge is rising when polarity is low, change edge the other
  assign capEdge = (sck != sckQ) && (sck == !cpol);
  assign chgEdge = (sck != sckQ) && (sck == cpol);
  // msb first both ways; the line flips once its bits are used up
  always @(posedge sys_clk) begin
    sckQ <= sck;
    if (load) begin
      capCnt <= 4'h0;
      sin <= txByte[7];
    end else if (capEdge) begin
      rxByte <= {rxByte[6:0], sout};
      capCnt <= capCnt + 4'h1;
    end else if (chgEdge) begin
      if (capCnt > 4'h7)
        sin <= !sin;
      else
        sin <= txByte[3'h7 - capCnt[2:0]];
    end
  end
endmodule

/* spp_top_test.sv */
`timescale 1ns/1ps
`include "spp_params.svh"
module spp_top_test;
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic regWr = 1'h0, regRd = 1'h0, sckIn = 1'h0, tbSin = 1'h0;
  logic useTb = 1'h0, cpol = 1'h0, load = 1'h1;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, txByte = 8'h3c;
  logic [7:0] regRdata, rxByte;
  logic [3:0] capCnt;
  logic sinPin, farSin, sckOut, sckOe, soutData, soutSel, irqReq;
  int miscompares = 0;
  int testsRun = 0;

  always #2 sys_clk = ~sys_clk;
  // serial input comes from the far end unless a test drives it
  assign sinPin = useTb ? tbSin : farSin;

  spp_top dut (.sys_clk, .rst, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .sinPin, .sckIn, .sckOut, .sckOe, .soutData, .soutSel,
    .irqReq);
  spp_far_end far (.sys_clk, .sck(sckOut), .sout(soutData), .sin(farSin),
    .cpol, .load, .txByte, .rxByte, .capCnt);

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    testsRun++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // settle after an edge so registered outputs are seen
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWr <= 1'h1;
    regAddr <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWr <= 1'h0;
    #1;
  endtask

  // read data appear in the cycle after the strobe and hold until the next read
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    regRd <= 1'h1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'h0;
    #1;
    chk(regRdata, e);
  endtask

  task automatic waitIrq(input int n);
    for (int i = 0; i < n && irqReq !== 1'h1; i++)
      tick;
  endtask

  task automatic pulse;
    repeat (10) @(posedge sys_clk);
    sckIn <= 1'h1;
    repeat (10) @(posedge sys_clk);
    sckIn <= 1'h0;
  endtask

  task automatic t_reset;
    rdc(`SPP_ADDR_MODE, 8'h00);
    rdc(`SPP_ADDR_RATE, 8'h00);
    rdc(`SPP_ADDR_ROUTE, 8'h00);
    rdc(8'h10, 8'h00);
    chk(sckOe, 1'h0);
    wr(`SPP_ADDR_ROUTE, 8'h01);
    chk(soutSel, 1'h1);
    wr(`SPP_ADDR_ROUTE, 8'h00);
    chk(soutSel, 1'h0);
    // run with frame length 0 must not start; mode bits still land
    wr(`SPP_ADDR_MODE, 8'hd0);
    rdc(`SPP_ADDR_MODE, 8'h50);
  endtask

  // all four polarity and phase settings, full byte both ways
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      cpol <= m[0];
      wr(`SPP_ADDR_ROUTE, 8'h01);
      wr(`SPP_ADDR_DATA, 8'ha5);
      wr(`SPP_ADDR_RATE, 8'h40);
      wr(`SPP_ADDR_MODE, {2'h1, m[1], 2'h3, 2'h0, m[0]});
      // clock pin input left quiet at 0 while we are master
      tick;
      chk(sckOut, m[0] ^ m[1]);
      chk(sckOe, 1'h1);
      load <= 1'h1;
      tick;
      load <= 1'h0;
      wr(`SPP_ADDR_MODE, {2'h3, m[1], 2'h3, 2'h0, m[0]});
      tick;
      tick;
      if (!m[1])
        chk(soutData, 1'h1);
      waitIrq(600);
      // far end sees the last edge one cycle after the design
      tick;
      chk(irqReq, 1'h1);
      chk(capCnt, 4'h8);
      chk(rxByte, 8'ha5);
      rdc(`SPP_ADDR_DATA, 8'h3c);
      rdc(`SPP_ADDR_MODE, {2'h1, m[1], 2'h3, 2'h0, m[0]});
      rdc(`SPP_ADDR_RATE, 8'hc0);
      wr(`SPP_ADDR_RATE, 8'h40);
      tick;
      chk(irqReq, 1'h0);
    end
  endtask

  // one bit frames, measure one half bit per divider code
  task automatic t_div;
    int n;
    int r;
    cpol <= 1'h0;
    for (int cd = 0; cd < 8; cd++) begin
      r = (cd == 7) ? 256 : (1 << cd);
      wr(`SPP_ADDR_RATE, {5'h01, cd[2:0]});
      wr(`SPP_ADDR_MODE, 8'hd0);
      for (n = 0; n < 4000 && sckOut !== 1'h1; n++)
        tick;
      for (n = 0; n < 4000 && sckOut !== 1'h0; n++)
        tick;
      chk(n[15:0], 16'(13 * r));
      waitIrq(4000);
      wr(`SPP_ADDR_RATE, {5'h01, cd[2:0]});
    end
  endtask

  // writes while running are dropped; zeros shift in
  task automatic t_lock;
    wr(`SPP_ADDR_RATE, 8'h20);
    wr(`SPP_ADDR_DATA, 8'ha5);
    wr(`SPP_ADDR_MODE, 8'hd0);
    wr(`SPP_ADDR_DATA, 8'hff);
    wr(`SPP_ADDR_RATE, 8'h7f);
    waitIrq(400);
    rdc(`SPP_ADDR_DATA, 8'h50);
    rdc(`SPP_ADDR_RATE, 8'ha0);
    wr(`SPP_ADDR_RATE, 8'h20);
    wr(`SPP_ADDR_RATE, 8'ha0);
    rdc(`SPP_ADDR_RATE, 8'h20);
  endtask

  task automatic t_abort;
    wr(`SPP_ADDR_RATE, 8'h40);
    wr(`SPP_ADDR_MODE, 8'hd0);
    repeat (20) tick;
    wr(`SPP_ADDR_MODE, 8'h50);
    tick;
    chk(irqReq, 1'h1);
    wr(`SPP_ADDR_RATE, 8'h40);
    wr(`SPP_ADDR_MODE, 8'h90);
    repeat (450) tick;
    chk(irqReq, 1'h0);
    rdc(`SPP_ADDR_RATE, 8'h40);
    rdc(`SPP_ADDR_MODE, 8'h10);
  endtask

  // gated start with input select low, input drops mid frame
  task automatic t_gate;
    useTb <= 1'h1;
    load <= 1'h1;
    tick;
    load <= 1'h0;
    wr(`SPP_ADDR_MODE, 8'hd4);
    repeat (60) tick;
    chk(capCnt, 4'h0);
    @(posedge sys_clk);
    tbSin <= 1'h1;
    repeat (30) @(posedge sys_clk);
    tbSin <= 1'h0;
    waitIrq(600);
    chk(capCnt, 4'h8);
    wr(`SPP_ADDR_RATE, 8'h40);
  endtask

  // slave on the clock pin, a glitch first that the filter eats
  task automatic t_slave;
    wr(`SPP_ADDR_MODE, 8'hc0);
    chk(sckOe, 1'h0);
    @(posedge sys_clk);
    sckIn <= 1'h1;
    @(posedge sys_clk);
    sckIn <= 1'h0;
    repeat (7) pulse;
    tick;
    chk(irqReq, 1'h0);
    pulse;
    repeat (8) tick;
    chk(irqReq, 1'h1);
    // filters bypassed: the same short glitch now makes a one-bit frame
    wr(`SPP_ADDR_RATE, 8'h08);
    wr(`SPP_ADDR_MODE, 8'hc2);
    @(posedge sys_clk);
    sckIn <= 1'h1;
    @(posedge sys_clk);
    sckIn <= 1'h0;
    repeat (8) tick;
    chk(irqReq, 1'h1);
  endtask

  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'h0;
    load <= 1'h0;
    t_reset;
    t_modes;
    t_div;
    t_lock;
    t_abort;
    t_gate;
    t_slave;
    test_done;
  end

  // cut a hang short well past the expected run length
  initial begin
    repeat (60000) @(posedge sys_clk);
    miscompares++;
    test_done;
  end
endmodule
